// ### logic/adc_control_register_one.sv
// Function
// - Writing one to bit 0 resets device and both control registers.
// - Software reset also clears FIFO pointers and stored offset.
// - After reset, five conversion clocks pass before first FIFO write.
// - Read bit 1 shows FIFO overflow flag.
// - Overflow flag clears after host reads the second control register.
// - Writing one to bit 1 flushes the FIFO.
// - Bits 2 and 3 pick trigger level that raises data-available.
// - Bit 4, reset one: data-available level when zero, pulse when one.
// - Bit 5, reset one: data-available active high when one, low when zero.
// - Bit 6 set: write strobe becomes read-write line, read strobe ignored.
// - Bit 7 selects two's complement when zero, straight binary when one.
// - Writing one to bit 8 starts offset calibration with inputs forced zero.
// - Calibration result held and subtracted from later results until reset.
// - Bit 9 enables debug readback of both control registers.
// - Debug: first read gives register 0, second gives register 1.
// - Trigger codes map to value counts depending on channel count.
// - Level mode: inactive on first read, recheck after trigger-count reads.
// - Pulse lasts 80 ns (AV_PULSE_CYC clocks); no new pulse until values read.
`timescale 1ns/100ps
module adc_control_register_one #(
  parameter int FIFO_DEPTH   = adc_ctrl_pkg::FIFO_DEPTH,
  parameter int AV_PULSE_CYC = adc_ctrl_pkg::AV_PULSE_CYC
) (
  input  wire logic                              i_clk,
  input  wire logic                              i_rst_b,
  input  wire adc_ctrl_pkg::host_bus_t           i_bus,
  output logic [adc_ctrl_pkg::SAMPLE_W-1:0]      o_data,
  output logic                                   o_data_oe_b,
  input  wire logic                              i_conv_tick,
  input  wire logic                              i_conv_valid,
  input  wire logic [adc_ctrl_pkg::SAMPLE_W-1:0] i_conv_data,
  input  wire logic [1:0]                        i_chans_m1,
  output logic                                   o_cal_force_zero,
  output logic                                   o_data_available_output,
  output logic [adc_ctrl_pkg::CR_W-1:0]          o_cr0
);
  localparam int SW = adc_ctrl_pkg::SAMPLE_W;
  localparam int CW = $clog2(FIFO_DEPTH+1);
  localparam int PW = $clog2(AV_PULSE_CYC+1);

  typedef struct packed {
    logic [9:0]    cr0;
    logic [1:0]    trig;
    logic          av_pulse;
    logic          av_pol;
    logic          rw_comb;
    logic          fmt;
    logic          register_readback_enable;
    logic          fifo_overflow_flag;
    logic [SW-1:0] offset;
    logic          cal_pend;
    logic [2:0]    start_cnt;
    logic          rd_act;
    logic          wr_act;
    logic [1:0]    register_readback_enable_cnt;
    logic          av_active;
    logic          armed;
    logic [4:0]    reads_left;
    logic [PW-1:0] pulse_cnt;
    logic [SW-1:0] dout;
    logic          flush;
  } state_t;

  localparam state_t ST_RST = '{
    cr0:       adc_ctrl_pkg::CR0_RESET,
    trig:      adc_ctrl_pkg::TRIG_RESET,
    av_pulse:  adc_ctrl_pkg::AV_PULSE_RST,
    av_pol:    adc_ctrl_pkg::AV_POL_RST,
    start_cnt: adc_ctrl_pkg::STARTUP_TICKS,
    armed:     1'b1,
    default:   '0
  };

  state_t        st_r;
  state_t        st_nxt;
  logic          cs_act;
  logic          rd_int;
  logic          wr_int;
  logic          rd_start;
  logic          wr_start;
  logic          push_valid;
  logic [SW-1:0] push_data;
  logic [SW-1:0] corrected;
  logic          fifo_in_ready;
  logic          fifo_out_valid;
  logic          fifo_pop;
  logic [SW-1:0] fifo_out_data;
  logic [CW-1:0] fifo_count;
  logic [4:0]    tl;
  logic [9:0]    cr1_image;

  // Internal strobes from chip selects and strobe pins
  assign cs_act = !i_bus.cs0_b && i_bus.cs1;
  assign rd_int = cs_act && (st_r.rw_comb ? i_bus.wr_b : (!i_bus.rd_b && i_bus.wr_b));
  assign wr_int = cs_act && (st_r.rw_comb ? !i_bus.wr_b : (!i_bus.wr_b && i_bus.rd_b));
  assign rd_start = rd_int && !st_r.rd_act;
  assign wr_start = wr_int && !st_r.wr_act;

  assign cr1_image = {st_r.register_readback_enable, 1'b0, st_r.fmt, st_r.rw_comb, st_r.av_pol, st_r.av_pulse,
                      st_r.trig, st_r.fifo_overflow_flag, 1'b0};

  assign corrected = i_conv_data - st_r.offset;
  // Binary format flips the sign bit
  assign push_data = st_r.fmt ? {~corrected[SW-1], corrected[SW-2:0]} : corrected;
  assign push_valid = i_conv_valid && (st_r.start_cnt == 3'h0) && !st_r.cal_pend;

  // FIFO pops only on plain data reads
  assign fifo_pop = rd_start && (st_r.register_readback_enable_cnt == 2'h0) && !i_bus.reg_sel;

  assign tl = adc_ctrl_pkg::trigger_level(i_chans_m1, st_r.trig);

  // Data outputs and side controls
  assign o_data           = st_r.dout;
  assign o_data_oe_b      = !rd_int;
  assign o_cr0            = st_r.cr0;
  // Inputs forced to zero while calibrating
  assign o_cal_force_zero = st_r.cal_pend;
  assign o_data_available_output = st_r.av_pol ? st_r.av_active : !st_r.av_active;

  sample_fifo #(
    .W     (SW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_rst_b     (i_rst_b),
    .i_flush     (st_r.flush),
    .i_in_valid  (push_valid),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (push_data),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (fifo_pop),
    .o_out_data  (fifo_out_data),
    .o_count     (fifo_count)
  );

  // Next-state logic for the whole register bank
  always_comb begin
    st_nxt        = st_r;
    st_nxt.rd_act = rd_int;
    st_nxt.wr_act = wr_int;
    st_nxt.flush  = 1'b0;

    // Startup count runs on conversion clock ticks
    if (i_conv_tick && st_r.start_cnt != 3'h0) begin
      st_nxt.start_cnt = st_r.start_cnt - 3'h1;
    end

    if (i_conv_valid && st_r.start_cnt == 3'h0 && st_r.cal_pend) begin
      st_nxt.offset   = i_conv_data;
      st_nxt.cal_pend = 1'b0;
    end

    // Host reads
    if (rd_start) begin
      if (st_r.register_readback_enable_cnt != 2'h0) begin
        // Register 0 first, then register 1
        st_nxt.dout      = (st_r.register_readback_enable_cnt == adc_ctrl_pkg::REGISTER_READBACK_ENABLE_READS) ? SW'(st_r.cr0) : SW'(cr1_image);
        st_nxt.register_readback_enable_cnt = st_r.register_readback_enable_cnt - 2'h1;
      end else if (i_bus.reg_sel) begin
        st_nxt.dout = SW'(cr1_image);
        st_nxt.fifo_overflow_flag = 1'b0;
      end else if (fifo_out_valid) begin
        st_nxt.dout = fifo_out_data;
      end
    end

    // Trigger bookkeeping on data reads
    if (fifo_pop && fifo_out_valid && !st_r.armed) begin
      if (!st_r.av_pulse) begin
        st_nxt.av_active = 1'b0;
      end
      if (st_r.reads_left <= 5'h01) begin
        st_nxt.reads_left = 5'h00;
        st_nxt.armed      = 1'b1;
      end else begin
        st_nxt.reads_left = st_r.reads_left - 5'h01;
      end
    end

    if (st_r.av_pulse && st_r.av_active) begin
      if (st_r.pulse_cnt <= PW'(1)) begin
        st_nxt.av_active = 1'b0;
        st_nxt.pulse_cnt = '0;
      end else begin
        st_nxt.pulse_cnt = st_r.pulse_cnt - PW'(1);
      end
    end

    // Fill reaching trigger level fires output
    if (st_r.armed && !st_r.flush && tl != 5'h00 && 5'(fifo_count) >= tl) begin // Count is stale while flush pends
      st_nxt.armed      = 1'b0;
      st_nxt.av_active  = 1'b1;
      st_nxt.reads_left = tl;
      st_nxt.pulse_cnt  = PW'(AV_PULSE_CYC);
    end

    // Full FIFO drops result; set wins over read clear
    if (push_valid && !fifo_in_ready) begin
      st_nxt.fifo_overflow_flag = 1'b1;
    end

    // Host writes
    if (wr_start) begin
      if (!i_bus.reg_sel) begin
        st_nxt.cr0 = i_bus.data[9:0];
      end else if (i_bus.data[adc_ctrl_pkg::BIT_SWRST]) begin
        // Full soft reset of both registers
        st_nxt        = ST_RST;
        st_nxt.rd_act = rd_int;
        st_nxt.wr_act = wr_int;
        st_nxt.flush  = 1'b1;
      end else begin
        st_nxt.trig     = i_bus.data[adc_ctrl_pkg::BIT_TRIG_HI:adc_ctrl_pkg::BIT_TRIG_LO];
        st_nxt.av_pulse = i_bus.data[adc_ctrl_pkg::BIT_AV_PULSE];
        st_nxt.av_pol   = i_bus.data[adc_ctrl_pkg::BIT_AV_POL];
        st_nxt.rw_comb  = i_bus.data[adc_ctrl_pkg::BIT_RW_COMB];
        st_nxt.fmt      = i_bus.data[adc_ctrl_pkg::BIT_FMT];
        st_nxt.register_readback_enable    = i_bus.data[adc_ctrl_pkg::BIT_REGISTER_READBACK_ENABLE];
        // Debug readback armed on rising enable
        if (i_bus.data[adc_ctrl_pkg::BIT_REGISTER_READBACK_ENABLE] && !st_r.register_readback_enable) begin
          st_nxt.register_readback_enable_cnt = adc_ctrl_pkg::REGISTER_READBACK_ENABLE_READS;
        end
        if (i_bus.data[adc_ctrl_pkg::BIT_OFFSET]) begin
          st_nxt.cal_pend = 1'b1;
        end
        // Flush empties FIFO and rearms trigger
        if (i_bus.data[adc_ctrl_pkg::BIT_FLUSH]) begin
          st_nxt.flush      = 1'b1;
          st_nxt.armed      = 1'b1;
          st_nxt.av_active  = 1'b0;
          st_nxt.reads_left = 5'h00;
        end
      end
    end
  end

  // Single state register; hard reset shares the soft reset value
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// ### logic/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

  // Control register layout
  localparam int          CR_W          = 10;
  localparam int          SAMPLE_W      = 12;
  localparam int          FIFO_DEPTH    = 16;
  localparam int          BIT_SWRST     = 0;
  localparam int          BIT_FIFO_OVERFLOW_FLAG      = 1;
  localparam int          BIT_FLUSH     = 1;
  localparam int          BIT_TRIG_LO   = 2;
  localparam int          BIT_TRIG_HI   = 3;
  localparam int          BIT_AV_PULSE  = 4;
  localparam int          BIT_AV_POL    = 5;
  localparam int          BIT_RW_COMB   = 6;
  localparam int          BIT_FMT       = 7;
  localparam int          BIT_OFFSET    = 8;
  localparam int          BIT_REGISTER_READBACK_ENABLE     = 9;

  // Reset values
  localparam logic [9:0]  CR0_RESET     = 10'h000;
  localparam logic [1:0]  TRIG_RESET    = 2'h0;
  localparam logic        AV_PULSE_RST  = 1'b1;
  localparam logic        AV_POL_RST    = 1'b1;

  // Timing
  localparam logic [2:0]  STARTUP_TICKS = 3'h5;
  localparam int          CLK_NS        = 20;
  localparam int          AV_PULSE_NS   = 80;
  localparam int          AV_PULSE_CYC  = (AV_PULSE_NS / CLK_NS < 1) ? 1 : AV_PULSE_NS / CLK_NS;

  // Debug readback sequence length
  localparam logic [1:0]  REGISTER_READBACK_ENABLE_READS   = 2'h2;

  // Host bus pins, sampled synchronously
  typedef struct packed {
    logic                cs0_b;
    logic                cs1;
    logic                wr_b;
    logic                rd_b;
    logic                reg_sel;
    logic [SAMPLE_W-1:0] data;
  } host_bus_t;

  // Trigger level in values; zero marks a reserved code
  function automatic logic [4:0] trigger_level(input logic [1:0] chans_m1, input logic [1:0] code);
    logic [4:0] lvl;
    lvl = 5'h00;
    unique case (chans_m1)
      2'h0: lvl = (code == 2'h0) ? 5'h01 : (code == 2'h1) ? 5'h04 : (code == 2'h2) ? 5'h08 : 5'h0e;
      2'h1: lvl = (code == 2'h0) ? 5'h02 : (code == 2'h1) ? 5'h04 : (code == 2'h2) ? 5'h08 : 5'h0c;
      2'h2: lvl = (code == 2'h0) ? 5'h03 : (code == 2'h1) ? 5'h06 : (code == 2'h2) ? 5'h09 : 5'h0c;
      2'h3: lvl = (code == 2'h0) ? 5'h04 : (code == 2'h1) ? 5'h08 : (code == 2'h2) ? 5'h0c : 5'h00;
    endcase
    return lvl;
  endfunction

endpackage

// ### logic/sample_fifo.sv
`timescale 1ns/100ps
module sample_fifo #(
  parameter int W     = 12,
  parameter int DEPTH = 16
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_b,
  input  wire logic                       i_flush,
  input  wire logic                       i_in_valid,
  output logic                            o_in_ready,
  input  wire logic [W-1:0]               i_in_data,
  output logic                            o_out_valid,
  input  wire logic                       i_out_ready,
  output logic [W-1:0]                    o_out_data,
  output logic [$clog2(DEPTH+1)-1:0]      o_count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr_ptr;
    logic [AW-1:0]           rd_ptr;
    logic [CW-1:0]           count;
  } fifo_state_t;

  fifo_state_t st_r;
  fifo_state_t st_nxt;
  logic        push;
  logic        pop;

  // Honest flags straight from the count
  assign o_in_ready  = (st_r.count != CW'(DEPTH));
  assign o_out_valid = (st_r.count != '0);
  assign o_out_data  = st_r.mem[st_r.rd_ptr];
  assign o_count     = st_r.count;
  assign push        = i_in_valid && o_in_ready;
  assign pop         = i_out_ready && o_out_valid;

  // Pointer wrap relies on DEPTH being a power of two
  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wr_ptr] = i_in_data;
      st_nxt.wr_ptr           = st_r.wr_ptr + AW'(1);
    end
    if (pop) begin
      st_nxt.rd_ptr = st_r.rd_ptr + AW'(1);
    end
    st_nxt.count = st_r.count + CW'(push) - CW'(pop);
    if (i_flush) begin
      st_nxt.wr_ptr = '0;
      st_nxt.rd_ptr = '0;
      st_nxt.count  = '0;
    end
  end

  // Hard reset clears storage too; flush resets only pointers and count
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// ### verif/adc_control_register_one_assertions.sv
`timescale 1ns/100ps
module adc_reg_checker #(
  parameter int FIFO_DEPTH   = 16,
  parameter int AV_PULSE_CYC = 4
) (
  input wire logic                    i_clk,
  input wire logic                    i_rst_b,
  input wire adc_ctrl_pkg::host_bus_t i_bus,
  input wire logic [11:0]             o_data,
  input wire logic                    o_data_oe_b,
  input wire logic                    i_conv_valid,
  input wire logic                    o_cal_force_zero,
  input wire logic                    o_data_available_output,
  input wire logic [9:0]              o_cr0
);
  // Single domain, synchronous reset
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  // Reset values land one edge after reset is seen
  reset_state_a: assert property (disable iff (1'b0)
    !i_rst_b |=> o_cr0 == 10'h000 && o_data == 12'h000 && !o_cal_force_zero && !o_data_available_output)
    else $error("outputs not at reset values");
  read_drive_a: assert property (
    !i_bus.cs0_b && i_bus.cs1 && !i_bus.rd_b && i_bus.wr_b |-> !o_data_oe_b)
    else $error("read buffer not driven during read");
  quiet_drive_a: assert property (
    i_bus.cs0_b || !i_bus.cs1 || !i_bus.wr_b |-> o_data_oe_b)
    else $error("read buffer driven without read");
  // Two idle edges: neither a read nor a soft reset can move these
  data_hold_a: assert property (
    i_bus.cs0_b && $past(i_bus.cs0_b) |=> $stable(o_data))
    else $error("read data moved while bus idle");
  cr0_hold_a: assert property (
    i_bus.cs0_b && $past(i_bus.cs0_b) |=> $stable(o_cr0))
    else $error("register 0 moved while bus idle");
  cal_start_a: assert property (
    $rose(o_cal_force_zero) |-> $past(i_bus.data[8] && i_bus.reg_sel && !i_bus.cs0_b)
      || $past(i_bus.data[8] && i_bus.reg_sel && !i_bus.cs0_b, 2))
    else $error("calibration started without write");
  cal_end_a: assert property (
    $fell(o_cal_force_zero) |-> $past(i_conv_valid) || $past(!i_bus.cs0_b && i_bus.data[0]) || !$past(i_rst_b))
    else $error("calibration ended without conversion");
  cal_wait_a: assert property (
    o_cal_force_zero && !i_conv_valid && i_bus.cs0_b |=> o_cal_force_zero)
    else $error("calibration dropped early");
endmodule

bind adc_control_register_one adc_reg_checker #(.FIFO_DEPTH(FIFO_DEPTH), .AV_PULSE_CYC(AV_PULSE_CYC)) u_adc_reg_checker (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_bus(i_bus), .o_data(o_data), .o_data_oe_b(o_data_oe_b),
  .i_conv_valid(i_conv_valid), .o_cal_force_zero(o_cal_force_zero),
  .o_data_available_output(o_data_available_output), .o_cr0(o_cr0));

// ### verif/adc_control_register_one_tb.sv
`timescale 1ns/100ps
module adc_control_register_one_tb;
  logic                    clk;
  logic                    rst_b;
  logic                    oe_b;
  logic                    cal;
  logic                    dav;
  logic                    tick;
  logic                    valid;
  logic                    en;
  logic                    comb;
  logic [11:0]             rdata;
  logic [1:0]              chans;
  logic [11:0]             cdata;
  logic [9:0]              cr0;
  adc_ctrl_pkg::host_bus_t bus;
  int                      num_errors;
  int                      checked;
  int                      w;
  int                      g;

  adc_control_register_one u_adc_control_register_one (.i_clk(clk), .i_rst_b(rst_b), .i_bus(bus), .o_data(rdata),
    .o_data_oe_b(oe_b), .i_conv_tick(tick), .i_conv_valid(valid), .i_conv_data(cdata), .i_chans_m1(chans),
    .o_cal_force_zero(cal), .o_data_available_output(dav), .o_cr0(cr0));
  conv_source_model u_conv_source_model (.i_clk(clk), .i_en(en), .i_force_zero(cal), .o_tick(tick),
    .o_valid(valid), .o_data(cdata));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task end_of_test;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task done(input string s);
    $display("end of test %s", s);
  endtask

  // One access: strobe for one edge, then at least two idle edges before the next
  task acc(input logic rd, input logic sel, input logic [11:0] d);
    @(posedge clk);
    bus <= '{cs0_b: 1'b0, cs1: 1'b1, wr_b: rd, rd_b: comb ? 1'b0 : !rd, reg_sel: sel, data: d};
    @(posedge clk);
    bus <= '{cs0_b: 1'b1, cs1: 1'b0, wr_b: 1'b1, rd_b: 1'b1, reg_sel: sel, data: ~d};
    @(posedge clk);
    #1;
  endtask

  task rdc(input logic sel, input logic [11:0] exp, input string nm);
    acc(1'b1, sel, 12'h000);
    chk(nm, exp, rdata);
  endtask

  // Let exactly n results through; bounded so a stuck model cannot hang
  // Valid is looked at once settled, ahead of the edge that takes it
  task conv(input int n);
    int i;
    int k;
    i = 0;
    k = 0;
    @(posedge clk);
    en <= 1'b1;
    while (i < n && k < 400) begin
      #1;
      if (valid === 1'b1) i++;
      @(posedge clk);
      k++;
    end
    en <= 1'b0;
    if (i < n) begin
      num_errors++;
      end_of_test();
    end
    #1;
  endtask

  task settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  // Main sequence
  initial begin
    rst_b = 1'b0;
    en = 1'b0;
    comb = 1'b0;
    chans = 2'h0;
    num_errors = 0;
    checked = 0;
    bus = '{cs0_b: 1'b1, cs1: 1'b0, wr_b: 1'b1, rd_b: 1'b1, reg_sel: 1'b0, data: 12'h000};
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    en <= 1'b1;
    conv(4);
    rdc(1'b0, 12'h000, "startup fifo");
    rdc(1'b1, 12'h030, "cr1 reset");
    chk("dav idle", 12'h000, {11'h000, dav});
    done("reset");
    conv(1);
    g = 0;
    while (dav !== 1'b1 && g < 20) begin
      @(posedge clk);
      #1;
      g++;
    end
    w = 0;
    while (dav === 1'b1 && w < 20) begin
      @(posedge clk);
      #1;
      w++;
    end
    if (g == 20 || w == 20) begin
      num_errors++;
      end_of_test();
    end
    chk("pulse width", 12'(adc_ctrl_pkg::AV_PULSE_CYC), 12'(w));
    conv(16);
    rdc(1'b1, 12'h032, "overflow set");
    rdc(1'b1, 12'h030, "overflow clear");
    rdc(1'b0, 12'h104, "first sample");
    done("overflow");
    acc(1'b0, 1'b1, 12'h0b2);
    rdc(1'b0, 12'h104, "flushed fifo");
    rdc(1'b1, 12'h0b0, "one shot bits");
    conv(1);
    rdc(1'b0, 12'h915, "binary format");
    done("flush");
    acc(1'b0, 1'b1, 12'h086);
    chk("dav low idle", 12'h001, {11'h000, dav});
    conv(3);
    settle();
    chk("dav below level", 12'h001, {11'h000, dav});
    conv(1);
    settle();
    chk("dav at level", 12'h000, {11'h000, dav});
    rdc(1'b0, 12'h916, "level read");
    chk("dav after read", 12'h001, {11'h000, dav});
    done("level");
    acc(1'b0, 1'b1, 12'h186);
    chk("cal force", 12'h001, {11'h000, cal});
    conv(1);
    @(posedge clk);
    #1;
    chk("cal done", 12'h000, {11'h000, cal});
    conv(1);
    settle();
    rdc(1'b0, 12'h90b, "offset removed");
    done("offset");
    acc(1'b0, 1'b0, 12'h2a5);
    chk("cr0", 12'h2a5, {2'h0, cr0});
    acc(1'b0, 1'b1, 12'h2b0);
    rdc(1'b0, 12'h2a5, "debug first");
    rdc(1'b0, 12'h2b0, "debug second");
    done("debug");
    acc(1'b0, 1'b1, 12'h0f0);
    comb = 1'b1;
    rdc(1'b1, 12'h0f0, "combined read");
    conv(2);
    acc(1'b0, 1'b1, 12'h001);
    comb = 1'b0;
    rdc(1'b1, 12'h030, "cr1 after reset");
    chk("cr0 after reset", 12'h000, {2'h0, cr0});
    rdc(1'b0, 12'h030, "fifo after reset");
    repeat (40) @(posedge clk);
    conv(1);
    settle();
    rdc(1'b0, 12'h11e, "offset cleared");
    done("soft reset");
    // Two channels: lowest code needs two values, not one
    chans <= 2'h1;
    acc(1'b0, 1'b1, 12'h022);
    conv(1);
    settle();
    chk("dav two chan one", 12'h000, {11'h000, dav});
    conv(1);
    settle();
    chk("dav two chan two", 12'h001, {11'h000, dav});
    done("channels");
    end_of_test();
  end
endmodule

// ### verif/conv_source_model.sv
`timescale 1ns/100ps
module conv_source_model #(
  parameter logic [11:0] CAL_CODE = 12'h010
) (
  input wire logic    i_clk,
  input wire logic    i_en,
  input wire logic    i_force_zero,
  output logic        o_tick,
  output logic        o_valid,
  output logic [11:0] o_data
);
  logic [1:0]  phase_r = 2'h0;
  logic [11:0] seq_r   = 12'h000;

  // Conversion clock runs free, one tick every four cycles
  always_ff @(posedge i_clk) begin
    phase_r <= phase_r + 2'h1;
    if (o_valid) begin
      seq_r <= seq_r + 12'h001;
    end
  end

  assign o_tick  = (phase_r == 2'h3);
  assign o_valid = o_tick & i_en;
  // grounded inputs
  // Off-result cycles show inverted data so stale values never look valid
  assign o_data  = !o_valid ? ~(12'h100 + seq_r) : i_force_zero ? CAL_CODE : 12'h100 + seq_r;
endmodule
